// ==== rtl/tmr_pkg.sv ====
// constants, field layout and phase type of the timer/counter block
// assumes one oscillator clock at 20 MHz and an Avalon-MM word bus
package tmr_pkg;

  // clock and phase timing
  localparam int CLK_HZ = 20_000_000;
  localparam int TOSC_NS = 50;
  localparam int PHASES_PER_CYCLE = 4;

  // write inhibit, in instruction cycles, and its count of clocks
  localparam int INHIBIT_INSTR = 2;
  localparam int INHIBIT_CNT = INHIBIT_INSTR * PHASES_PER_CYCLE;
  localparam int INHIB_W = 4;

  // rollover delay after the overflow pulse
  localparam int ROLL_DELAY_TOSC = 3;
  localparam int ROLL_DELAY_NS = ROLL_DELAY_TOSC * TOSC_NS;
  localparam int ROLL_DELAY_CYC = (ROLL_DELAY_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  // bus shape
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int IDX_W = 8;

  // register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_COUNT = 8'h01;
  localparam logic [IDX_W-1:0] IDX_IRQ_CTRL = 8'h0B;
  localparam logic [IDX_W-1:0] IDX_OPTION = 8'h81;
  localparam logic [IDX_W-1:0] IDX_AUX_CTRL = 8'h90;

  // option register fields
  localparam int OPT_CS_BIT = 5;
  localparam int OPT_SE_BIT = 4;
  localparam int OPT_PSA_BIT = 3;
  localparam int OPT_RATIO_LSB = 0;
  localparam int RATIO_W = 3;

  // irq_control fields
  localparam int IRQ_EN_BIT = 5;
  localparam int IRQ_FLAG_BIT = 2;

  // aux control fields
  localparam int AUX_SLEEP_BIT = 0;
  localparam int AUX_WDT_CLR_BIT = 1;

  // values after reset, and the count maximum
  localparam logic [7:0] OPTION_RST = 8'hFF;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;

  // prescaler width
  localparam int PRESC_W = 8;

  typedef enum logic [3:0] {
    PH_Q1 = 4'h1,
    PH_Q2 = 4'h2,
    PH_Q3 = 4'h4,
    PH_Q4 = 4'h8
  } phase_t;

endpackage

// ==== rtl/presc_if.sv ====
// signals between the timer core and the shared prescaler
// assumes the core owns ratio and clear, the prescaler owns out
`timescale 1ns/1ps
interface presc_if;
  logic in_pulse;
  logic clear;
  logic [tmr_pkg::RATIO_W-1:0] ratio;
  logic out;

  modport owner (
    output in_pulse,
    output clear,
    output ratio,
    input out
  );

  modport unit (
    input in_pulse,
    input clear,
    input ratio,
    output out
  );
endinterface

// ==== rtl/shared_prescaler.sv ====
// eight-bit shared prescaler with a tapped, symmetrical output
// assumes in_pulse and clear are one-clock pulses from the owner
`timescale 1ns/1ps
module shared_prescaler (
  // clock, reset and enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // owner side
  presc_if.unit p
);
  import tmr_pkg::*;

  logic [PRESC_W-1:0] cnt_q;

  // counter with no software path, cleared only by reset or as a side effect
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (ce) begin
      if (p.clear) begin // R18
        cnt_q <= '0;
      end else if (p.in_pulse) begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end

  // tap n halves n plus one times, so ratio 0 gives 1:2 and 7 gives 1:256
  assign p.out = cnt_q[p.ratio]; // R6 R23

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_clear_to_zero: assert property ((ce && p.clear) |=> cnt_q == 8'h00) // R18
    else $error("prescaler not zero after clear");

  a_count_step: assert property ((ce && p.in_pulse && !p.clear)
                                 |=> cnt_q == $past(cnt_q) + 8'h01) // R18
    else $error("prescaler missed an input pulse");

endmodule

// ==== rtl/timer_counter.sv ====
// eight-bit timer/counter with shared prescaler and overflow flag
// assumes an Avalon-MM master, a synchronous count pin and a watchdog
// outside that supplies its oscillator tick and takes tick and clear
`timescale 1ns/1ps

// Notes on behaviour
// R1: clock source select cleared counts one per instruction cycle without prescaler
// R2: after a count write, counting pauses two instruction cycles, then resumes
// R3: clock source select set counts edges of the external count input
// R4: source edge select cleared counts rising edges, set counts falling
// R5: prescaler assign cleared gives prescaler to timer, set to watchdog
// R6: timer prescaler divides by a power of two from 1:2 to 1:256
// R7: count wrap from FFh to 00h sets the overflow flag
// R8: interrupt request only while the overflow interrupt enable is set
// R9: overflow flag stays set until software clears it
// R10: timer does not count during sleep
// R11: prescaler output or raw input is sampled on phases two and four
// R12: without prescaler the pin stays high and low two oscillator periods
// R13: with prescaler the pin period is four oscillator periods over ratio
// R14: counter increments three to seven oscillator periods after pin change
// R15: any count write clears the prescaler while the timer owns it
// R16: watchdog clear clears the prescaler while the watchdog owns it
// R17: only one owner; the other runs undivided
// R18: prescaler is eight bits with no software read or write
// R19: overflow pulse sets flag at once; count rolls three periods later
// R20: overflow flag is sampled on phase one of every instruction cycle
// R21: software clears count and watchdog before moving prescaler to watchdog
// R22: instruction cycle is four oscillator periods in four phases
// R23: ratio field value n selects a prescale of two to n plus one
module timer_counter (
  // clock, reset and enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // register bus
  input wire logic [tmr_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [tmr_pkg::DATA_W-1:0] avs_writedata,
  output logic [tmr_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // count pin
  input wire logic ext_count_input,
  // watchdog side
  input wire logic wdt_osc_tick,
  output logic wdt_tick,
  output logic wdt_clear,
  // interrupt request
  output logic overflow_irq
);
  import tmr_pkg::*;

  phase_t phase_q;
  logic [DATA_W-1:0] readdata_q;
  logic wait_q;
  logic [7:0] count_q;
  logic [7:0] option_q;
  logic en_q;
  logic flag_q;
  logic sleep_q;
  logic irq_q;
  logic wdt_tick_q;
  logic wdt_clear_q;
  logic src_prev_q;
  logic presc_prev_q;
  logic samp_q;
  logic tick_q;
  logic [INHIB_W-1:0] inhib_q;
  logic [ROLL_DELAY_CYC-1:0] pipe_q;

  logic acc_done;
  logic wr_low;
  logic wr_count;
  logic wr_irq;
  logic wr_option;
  logic wr_aux;
  logic wdt_clr_req;
  logic cs;
  logic se;
  logic prescaler_assign;
  logic cyc_level;
  logic samp_en;
  logic src_level;
  logic src_rise;
  logic timer_src;
  logic tick_ok;
  logic flag_set;
  logic [DATA_W-1:0] rd_word;

  presc_if p ();

  shared_prescaler u_presc (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .p(p)
  );

  // register index match on a byte address
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                   input logic [IDX_W-1:0] idx);
    reg_hit = (addr[ADDR_W-1:2] == idx);
  endfunction

  // four phases per instruction cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      phase_q <= PH_Q1;
    end else if (ce) begin
      unique case (phase_q) // R22
        PH_Q1: phase_q <= PH_Q2;
        PH_Q2: phase_q <= PH_Q3;
        PH_Q3: phase_q <= PH_Q4;
        PH_Q4: phase_q <= PH_Q1;
        default: phase_q <= PH_Q1;
      endcase
    end
  end

  assign cyc_level = (phase_q == PH_Q1) || (phase_q == PH_Q2);
  assign samp_en = (phase_q == PH_Q2) || (phase_q == PH_Q4);

  // bus slave: waitrequest drops one cycle after a request, access ends there
  assign acc_done = (avs_read || avs_write) && !wait_q;
  assign wr_low = acc_done && avs_write && avs_byteenable[0];
  assign wr_count = wr_low && reg_hit(avs_address, IDX_COUNT);
  assign wr_irq = wr_low && reg_hit(avs_address, IDX_IRQ_CTRL);
  assign wr_option = wr_low && reg_hit(avs_address, IDX_OPTION);
  assign wr_aux = wr_low && reg_hit(avs_address, IDX_AUX_CTRL);
  assign wdt_clr_req = wr_aux && avs_writedata[AUX_WDT_CLR_BIT];

  always_comb begin
    rd_word = '0;
    if (reg_hit(avs_address, IDX_COUNT)) begin
      rd_word[7:0] = count_q;
    end else if (reg_hit(avs_address, IDX_IRQ_CTRL)) begin
      rd_word[IRQ_EN_BIT] = en_q;
      rd_word[IRQ_FLAG_BIT] = flag_q;
    end else if (reg_hit(avs_address, IDX_OPTION)) begin
      rd_word[7:0] = option_q;
    end else if (reg_hit(avs_address, IDX_AUX_CTRL)) begin
      rd_word[AUX_SLEEP_BIT] = sleep_q;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wait_q <= 1'b1;
      readdata_q <= '0;
    end else if (ce) begin
      if ((avs_read || avs_write) && wait_q) begin
        wait_q <= 1'b0;
        readdata_q <= avs_read ? rd_word : '0;
      end else begin
        wait_q <= 1'b1;
      end
    end
  end

  // option register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      option_q <= OPTION_RST;
    end else if (ce && wr_option) begin
      option_q <= avs_writedata[7:0];
    end
  end

  assign cs = option_q[OPT_CS_BIT];
  assign se = option_q[OPT_SE_BIT];
  assign prescaler_assign = option_q[OPT_PSA_BIT];

  // sleep and watchdog clear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sleep_q <= 1'b0;
      wdt_clear_q <= 1'b0;
    end else if (ce) begin
      if (wr_aux) begin
        sleep_q <= avs_writedata[AUX_SLEEP_BIT];
      end
      wdt_clear_q <= wdt_clr_req;
    end
  end

  // count source: instruction clock or pin, edge chosen by xor
  assign src_level = cs ? (ext_count_input ^ se) : cyc_level; // R1 R3 R4
  assign src_rise = src_level && !src_prev_q;

  // prescaler routing and side-effect clears
  assign p.in_pulse = prescaler_assign ? wdt_osc_tick : src_rise; // R5
  assign p.ratio = option_q[OPT_RATIO_LSB +: RATIO_W]; // R6 R23
  assign p.clear = (wr_count && !prescaler_assign) || (wdt_clr_req && prescaler_assign); // R15 R16

  // non-owner runs undivided
  assign timer_src = prescaler_assign ? src_level : p.out; // R17

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      src_prev_q <= 1'b1;
      presc_prev_q <= 1'b0;
      wdt_tick_q <= 1'b0;
    end else if (ce) begin
      src_prev_q <= src_level;
      presc_prev_q <= p.out;
      wdt_tick_q <= prescaler_assign ? (p.out && !presc_prev_q) : wdt_osc_tick; // R17
    end
  end

  // phase sampling of the timer clock, rising sample gives a tick
  // sampler resets high, so an idle high source gives no false tick
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      samp_q <= 1'b1;
      tick_q <= 1'b0;
    end else if (ce) begin
      if (samp_en) begin // R11
        samp_q <= timer_src;
        tick_q <= timer_src && !samp_q;
      end else begin
        tick_q <= 1'b0;
      end
    end
  end

  // tick is dropped in sleep and during the write inhibit
  assign tick_ok = tick_q && !sleep_q && (inhib_q == '0); // R10 R2
  assign flag_set = tick_ok && (count_q == COUNT_MAX); // R7 R19

  // write inhibit window
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      inhib_q <= '0;
    end else if (ce) begin
      if (wr_count) begin
        inhib_q <= INHIB_W'(INHIBIT_CNT); // R2
      end else if (inhib_q != '0) begin
        inhib_q <= inhib_q - 4'h1;
      end
    end
  end

  // increment delay line, count moves three clocks after the tick
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pipe_q <= '0;
    end else if (ce) begin
      if (wr_count) begin
        pipe_q <= '0;
      end else begin
        pipe_q <= {pipe_q[ROLL_DELAY_CYC-2:0], tick_ok}; // R14 R19
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      count_q <= COUNT_RST;
    end else if (ce) begin
      if (wr_count) begin
        count_q <= avs_writedata[7:0]; // R2
      end else if (pipe_q[ROLL_DELAY_CYC-1]) begin
        count_q <= count_q + 8'h01; // R1 R3
      end
    end
  end

  // overflow flag and enable, hardware set wins over a clear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      en_q <= 1'b0;
      flag_q <= 1'b0;
    end else if (ce) begin
      if (wr_irq) begin
        en_q <= avs_writedata[IRQ_EN_BIT];
      end
      flag_q <= flag_set || (wr_irq ? avs_writedata[IRQ_FLAG_BIT] : flag_q); // R7 R9
    end
  end

  // request sampled on phase one
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else if (ce && phase_q == PH_Q1) begin
      irq_q <= flag_q && en_q; // R8 R20
    end
  end

  assign avs_readdata = readdata_q;
  assign avs_waitrequest = wait_q;
  assign wdt_tick = wdt_tick_q;
  assign wdt_clear = wdt_clear_q;
  assign overflow_irq = irq_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_wrap_tick;
    ce && flag_set && !wr_count;
  endsequence

  sequence s_quiet3;
    (ce && !wr_count) [*3];
  endsequence

  sequence s_count_write;
    ce && wr_count;
  endsequence

  a_wrap_flag_now: assert property (s_wrap_tick |=> flag_q) // R7
    else $error("overflow tick did not set the flag");

  a_roll_delay: assert property (s_wrap_tick ##1 s_quiet3 |=> count_q == 8'h00) // R19
    else $error("count did not roll over three clocks after the tick");

  a_write_inhibit: assert property (s_count_write ##1 (ce && !wr_count) [*8]
                                    |=> count_q == $past(count_q, 8)) // R2
    else $error("count moved inside the write inhibit");

  a_flag_sticky: assert property ((ce && flag_q && !wr_irq) |=> flag_q) // R9
    else $error("overflow flag dropped without a clear");

  a_irq_q1_sample: assert property ((ce && phase_q == PH_Q1)
                                    |=> irq_q == $past(flag_q && en_q)) // R8
    else $error("request not sampled from flag and enable");

  a_irq_hold: assert property ((ce && phase_q != PH_Q1) |=> $stable(irq_q)) // R20
    else $error("request changed outside phase one");

  a_sleep_stops: assert property ((ce && sleep_q && pipe_q == '0 && !wr_count)
                                  |=> count_q == $past(count_q)) // R10
    else $error("count moved during sleep");

  a_sample_phase: assert property ((ce && !samp_en) |=> $stable(samp_q)) // R11
    else $error("sample taken outside phases two and four");

  a_presc_clr_tmr: assert property ((ce && wr_count && !prescaler_assign)
                                    |=> u_presc.cnt_q == 8'h00) // R15
    else $error("count write did not clear the prescaler");

  a_presc_clr_wdt: assert property ((ce && wdt_clr_req && prescaler_assign)
                                    |=> (wdt_clear_q && u_presc.cnt_q == 8'h00)) // R16
    else $error("watchdog clear did not clear the prescaler");

  a_wdt_undivided: assert property ((ce && !prescaler_assign && wdt_osc_tick) |=> wdt_tick_q) // R17
    else $error("watchdog tick divided while the timer owns the prescaler");

  a_timer_undivided: assert property ((ce && prescaler_assign && samp_en)
                                      |=> samp_q == $past(src_level)) // R17
    else $error("timer source divided while the watchdog owns the prescaler");

endmodule

// ==== sim/pulse_src.sv ====
// pulse source model driving the count pin
// assumes the bench calls its tasks; the pin moves just after sys_clk rises
`timescale 1ns/1ps
module pulse_src (
  // clock
  input wire logic sys_clk,
  // count pin
  output logic ext_count_input
);
  initial ext_count_input = 1'b0;

  task automatic set_level(input logic v);
    @(posedge sys_clk);
    ext_count_input <= v;
  endtask

  task automatic pulses(input int n, input int hi, input int lo);
    int h;
    int l;
    h = (hi < 2) ? 2 : hi;
    l = (lo < 2) ? 2 : lo;
    repeat (n) begin
      set_level(1'b1);
      repeat (h - 1) @(posedge sys_clk);
      set_level(1'b0);
      repeat (l - 1) @(posedge sys_clk);
    end
  endtask
endmodule

// ==== sim/tb_top.sv ====
// self-checking bench for the timer/counter block
// assumes the pulse source model and a 20 MHz clock
`timescale 1ns/1ps
module tb_top;
  import tmr_pkg::*;
  logic sys_clk;
  logic rst;
  logic [ADDR_W-1:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [DATA_W-1:0] avs_writedata;
  logic [DATA_W-1:0] avs_readdata;
  logic avs_waitrequest;
  logic ext_count_input;
  logic wdt_osc_tick;
  logic wdt_tick;
  logic wdt_clear;
  logic overflow_irq;
  int miscompares;
  int samples_checked;
  int tick_cnt = 0;
  int clr_cnt = 0;
  logic [7:0] rv;

  timer_counter dut (.sys_clk(sys_clk), .rst(rst), .ce(1'b1), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(4'hF),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ext_count_input(ext_count_input),
    .wdt_osc_tick(wdt_osc_tick), .wdt_tick(wdt_tick), .wdt_clear(wdt_clear),
    .overflow_irq(overflow_irq));
  pulse_src src (.sys_clk(sys_clk), .ext_count_input(ext_count_input));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // watchdog pulse counters
  always @(posedge sys_clk) begin
    if (wdt_tick === 1'b1) tick_cnt++;
    if (wdt_clear === 1'b1) clr_cnt++;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check1(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd,
      output logic [7:0] rd_v);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= {idx, 2'b00};
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= {24'h000000, wd};
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd_v = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 50) begin
      miscompares++;
      end_of_test();
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] x;
    bus(1'b1, idx, d, x);
  endtask

  task automatic rd(input logic [7:0] idx, output logic [7:0] d);
    bus(1'b0, idx, 8'h00, d);
  endtask

  // count difference between two reads sampled gap clocks apart
  task automatic rate(input int gap, output logic [7:0] diff);
    logic [7:0] a;
    logic [7:0] b;
    rd(IDX_COUNT, a);
    repeat (gap - 3) @(posedge sys_clk);
    rd(IDX_COUNT, b);
    diff = b - a;
  endtask

  task automatic osc(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      wdt_osc_tick <= 1'b1;
      @(posedge sys_clk);
      wdt_osc_tick <= 1'b0;
      repeat (2) @(posedge sys_clk);
    end
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic t_reset();
    rd(IDX_COUNT, rv);
    check8("count", COUNT_RST, rv);
    rd(IDX_OPTION, rv);
    check8("option", OPTION_RST, rv);
    rd(IDX_IRQ_CTRL, rv);
    check8("irq_control", 8'h00, rv);
    rd(8'h3F, rv);
    check8("unmapped", 8'h00, rv);
    repeat (20) @(posedge sys_clk);
    rd(IDX_COUNT, rv);
    check8("count idle", COUNT_RST, rv);
    $display("test reset done");
  endtask

  task automatic t_timer();
    wr(IDX_OPTION, 8'h08);
    repeat (20) @(posedge sys_clk);
    rate(40, rv);
    check8("timer rate", 8'h0A, rv);
    wr(IDX_COUNT, 8'h80);
    rd(IDX_COUNT, rv);
    check8("count after write", 8'h80, rv);
    rd(IDX_COUNT, rv);
    check8("count inhibited", 8'h80, rv);
    for (int r = 0; r < 4; r++) begin
      wr(IDX_OPTION, 8'(r));
      repeat (20) @(posedge sys_clk);
      rate(32 << r, rv);
      check8("prescaled rate", 8'h04, rv);
    end
    wr(IDX_OPTION, 8'h07);
    repeat (20) @(posedge sys_clk);
    rate(2048, rv);
    check8("slowest rate", 8'h02, rv);
    $display("test timer done");
  endtask

  task automatic t_ovf();
    int n;
    wr(IDX_OPTION, 8'h08);
    wr(IDX_IRQ_CTRL, 8'h20);
    wr(IDX_COUNT, 8'hFE);
    n = 0;
    while (overflow_irq !== 1'b1 && n < 100) begin
      @(negedge sys_clk);
      n++;
    end
    check1("irq raised", 1'b1, overflow_irq);
    if (n >= 100) begin
      end_of_test();
    end
    rd(IDX_IRQ_CTRL, rv);
    check8("flag set", 8'h24, rv);
    wr(IDX_IRQ_CTRL, 8'h04);
    repeat (8) @(negedge sys_clk);
    check1("irq masked", 1'b0, overflow_irq);
    rd(IDX_IRQ_CTRL, rv);
    check8("flag kept", 8'h04, rv);
    wr(IDX_IRQ_CTRL, 8'h00);
    rd(IDX_IRQ_CTRL, rv);
    check8("flag cleared", 8'h00, rv);
    wr(IDX_AUX_CTRL, 8'h01);
    repeat (4) @(posedge sys_clk);
    rate(40, rv);
    check8("sleep hold", 8'h00, rv);
    wr(IDX_AUX_CTRL, 8'h00);
    repeat (4) @(posedge sys_clk);
    rate(40, rv);
    check8("wake rate", 8'h0A, rv);
    $display("test overflow done");
  endtask

  task automatic t_counter();
    wr(IDX_OPTION, 8'h28);
    wr(IDX_COUNT, 8'h00);
    repeat (10) @(posedge sys_clk);
    src.pulses(5, 2, 2);
    repeat (10) @(posedge sys_clk);
    rd(IDX_COUNT, rv);
    check8("pin count", 8'h05, rv);
    wr(IDX_COUNT, 8'h00);
    repeat (10) @(posedge sys_clk);
    src.set_level(1'b1);
    repeat (6) @(posedge sys_clk);
    rd(IDX_COUNT, rv);
    check8("rising edge", 8'h01, rv);
    wr(IDX_OPTION, 8'h38);
    wr(IDX_COUNT, 8'h00);
    repeat (10) @(posedge sys_clk);
    rd(IDX_COUNT, rv);
    check8("no edge", 8'h00, rv);
    src.set_level(1'b0);
    repeat (6) @(posedge sys_clk);
    rd(IDX_COUNT, rv);
    check8("falling edge", 8'h01, rv);
    $display("test counter done");
  endtask

  task automatic t_wdt();
    int a;
    wr(IDX_OPTION, 8'h00);
    a = tick_cnt;
    osc(3);
    check8("wdt undivided", 8'h03, 8'(tick_cnt - a));
    wr(IDX_COUNT, 8'h00);
    a = clr_cnt;
    wr(IDX_AUX_CTRL, 8'h02);
    repeat (3) @(posedge sys_clk);
    check8("wdt clear", 8'h01, 8'(clr_cnt - a));
    wr(IDX_OPTION, 8'h08);
    wr(IDX_AUX_CTRL, 8'h02);
    repeat (3) @(posedge sys_clk);
    a = tick_cnt;
    osc(4);
    check8("wdt divided", 8'h02, 8'(tick_cnt - a));
    $display("test watchdog done");
  endtask

  initial begin
    rst = 1'b1;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    wdt_osc_tick = 1'b0;
    miscompares = 0;
    samples_checked = 0;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_timer();
    t_ovf();
    t_counter();
    t_wdt();
    end_of_test();
  end
endmodule
